// >>> hw/frame_stats_pkg.sv
// Shared widths and reset values for the payload tally and receive
// timestamp logic.
// Assumes every user imports the whole package in its module header.
package frame_stats_pkg;
	// Per-frame payload byte count width
	localparam int COUNT_W = 16;
	// Cumulative payload byte total width
	localparam int TOTAL_W = 64;
	// Wide (seconds plus nanoseconds plus fraction) time format width
	localparam int TOD_WIDE_W = 96;
	// Narrow time format width
	localparam int TOD_NARROW_W = 64;
	// Default width of the client fingerprint
	localparam int FP_W_DEFAULT = 8;
	// Reset values, one per register width except the fingerprint
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [TOTAL_W-1:0] TOTAL_RESET = 64'h0000_0000_0000_0000;
	localparam logic [TOD_WIDE_W-1:0] TOD_WIDE_RESET =
		96'h0000_0000_0000_0000_0000_0000;
	localparam logic [TOD_NARROW_W-1:0] TOD_NARROW_RESET =
		64'h0000_0000_0000_0000;
	// Output value of a format that is configured out
	localparam logic [TOD_WIDE_W-1:0] TOD_WIDE_ABSENT = TOD_WIDE_RESET;
	localparam logic [TOD_NARROW_W-1:0] TOD_NARROW_ABSENT = TOD_NARROW_RESET;
endpackage

// >>> hw/payload_tally.sv
// One direction of payload byte reporting: per-frame count with strobe
// and a cumulative total of qualifying frames.
// Assumes the frame end pulse and its error flags come from MAC logic on
// the same clock, valid together in one cycle.
module payload_tally
	import frame_stats_pkg::*;
#(
	parameter int CNT_W = COUNT_W,
	parameter int SUM_W = TOTAL_W,
	parameter bit KEEP_TOTAL = 1'b1
)
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic frame_end_in,
	input wire logic [CNT_W-1:0] payload_len_in,
	input wire logic fcs_err_in,
	input wire logic oversize_err_in,
	input wire logic undersize_err_in,
	input wire logic len_err_in,
	output logic [CNT_W-1:0] count_out,
	output logic strobe_out,
	output logic [SUM_W-1:0] total_out
);
	// Refuse widths that the reset constants cannot serve
	generate
		if (CNT_W != COUNT_W || SUM_W != TOTAL_W)
		begin : g_bad_width
			$error("payload_tally: widths must match package");
		end
	endgenerate

	// Any one error takes the frame out of reporting
	wire any_err = fcs_err_in | oversize_err_in | undersize_err_in |
		len_err_in;
	// Frame that is reported and summed
	wire qualify = frame_end_in & ~any_err;
	// Total after adding the count now on the outputs
	wire [SUM_W-1:0] next_total = total_out + SUM_W'(count_out);

	// Per-frame count and strobe; count held between strobes
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			count_out <= COUNT_RESET;
			strobe_out <= 1'b0;
		end
		else if (ce_in)
		begin
			// One pulse per qualifying frame, never per increment
			strobe_out <= qualify;
			if (qualify)
				count_out <= payload_len_in;
		end
	end

	// Cumulative total; absent option keeps it at zero
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			total_out <= TOTAL_RESET;
		else if (ce_in && KEEP_TOTAL && strobe_out)
			total_out <= next_total;
	end

	// Strobe follows only a clean frame end
	strobe_cause_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && frame_end_in && any_err) |=> !strobe_out)
		else $error("strobe after errored frame");

	// Count and strobe carry the frame length
	count_carry_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && qualify) |=>
			(strobe_out && count_out == $past(payload_len_in)))
		else $error("count or strobe missing");

	// Strobe only with a qualifying frame the cycle before
	strobe_only_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && !qualify) |=> !strobe_out)
		else $error("strobe without frame");

	// Summing happens on the strobe cycle, by the reported count
	generate
		if (KEEP_TOTAL)
		begin : g_sum_chk
			total_add_a: assert property (
				@(posedge clk_in) disable iff (srst_in)
				(ce_in && strobe_out) |=>
					total_out == $past(total_out) + $past(count_out))
				else $error("total not advanced by count");
			total_still_a: assert property (
				@(posedge clk_in) disable iff (srst_in)
				(!strobe_out || !ce_in) |=> $stable(total_out))
				else $error("total moved without strobe");
		end
	endgenerate
endmodule

// >>> hw/frame_octet_count_rx_timestamp.sv
// Top of the MAC client sideband: payload byte reporting for both
// directions and the receive arrival timestamp.
// Assumes one clock for both directions, link and client events from
// logic on that clock, and a time source updating every cycle.
module frame_octet_count_rx_timestamp
	import frame_stats_pkg::*;
#(
	// Statistics totals present
	parameter bit STATS_OPTION = 1'b1,
	// Precision time support present
	parameter bit precision_time_option = 1'b1,
	// Wide time format present
	parameter bit WIDE_OPTION = 1'b1,
	// Narrow time format present
	parameter bit NARROW_OPTION = 1'b1,
	// Fingerprint width
	parameter int FP_W = FP_W_DEFAULT
)
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Transmit frame end and its status
	input wire logic tx_frame_end_in,
	input wire logic [COUNT_W-1:0] tx_payload_len_in,
	input wire logic tx_fcs_err_in,
	input wire logic tx_oversize_err_in,
	input wire logic tx_undersize_err_in,
	input wire logic tx_len_err_in,
	// Receive frame end and its status
	input wire logic rx_frame_end_in,
	input wire logic [COUNT_W-1:0] rx_payload_len_in,
	input wire logic rx_fcs_err_in,
	input wire logic rx_oversize_err_in,
	input wire logic rx_undersize_err_in,
	input wire logic rx_len_err_in,
	// Receive packet first seen on the link
	input wire logic rx_link_arrival_in,
	// Receive start of packet on the client side
	input wire logic rx_client_sop_in,
	// Time source, both formats
	input wire logic [TOD_WIDE_W-1:0] rx_tod_input_wide_in,
	input wire logic [TOD_NARROW_W-1:0] rx_tod_input_narrow_in,
	// Client fingerprint with a timing packet
	input wire logic fp_valid_in,
	input wire logic [FP_W-1:0] fp_in,
	// Per-frame counts and strobes
	output logic [COUNT_W-1:0] tx_frame_payload_count_out,
	output logic tx_frame_payload_count_strobe_out,
	output logic [COUNT_W-1:0] rx_frame_payload_count_out,
	output logic rx_frame_payload_count_strobe_out,
	// Cumulative totals
	output logic [TOTAL_W-1:0] tx_payload_octet_total_out,
	output logic [TOTAL_W-1:0] rx_payload_octet_total_out,
	// Arrival timestamps and their qualifier
	output logic [TOD_WIDE_W-1:0] rx_arrival_time_wide_out,
	output logic [TOD_NARROW_W-1:0] rx_arrival_time_narrow_out,
	output logic rx_arrival_time_valid_out,
	// Fingerprint returned to the client
	output logic fp_valid_out,
	output logic [FP_W-1:0] fp_out
);
	// Refuse a fingerprint the ports cannot carry
	generate
		if (FP_W < 1 || FP_W > 32)
		begin : g_bad_fp
			$error("frame_octet_count_rx_timestamp: FP_W out of range");
		end
	endgenerate

	// Timestamp path states
	typedef enum logic [1:0] {
		TS_IDLE,
		TS_HELD,
		TS_SHOWN
	} ts_state_t;

	// Current and next timestamp path state
	ts_state_t ts_state;
	ts_state_t next_ts_state;
	// Captured time, one register per format
	logic [TOD_WIDE_W-1:0] held_wide;
	logic [TOD_NARROW_W-1:0] held_narrow;
	// Registered fingerprint pair
	logic fp_valid_q;
	logic [FP_W-1:0] fp_q;

	// Transmit direction: counts survive with totals configured out
	payload_tally #(
		.CNT_W(COUNT_W),
		.SUM_W(TOTAL_W),
		.KEEP_TOTAL(STATS_OPTION)
	) u_tx_tally (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.frame_end_in(tx_frame_end_in),
		.payload_len_in(tx_payload_len_in),
		.fcs_err_in(tx_fcs_err_in),
		.oversize_err_in(tx_oversize_err_in),
		.undersize_err_in(tx_undersize_err_in),
		.len_err_in(tx_len_err_in),
		.count_out(tx_frame_payload_count_out),
		.strobe_out(tx_frame_payload_count_strobe_out),
		.total_out(tx_payload_octet_total_out)
	);

	// Receive direction, same structure
	payload_tally #(
		.CNT_W(COUNT_W),
		.SUM_W(TOTAL_W),
		.KEEP_TOTAL(STATS_OPTION)
	) u_rx_tally (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.frame_end_in(rx_frame_end_in),
		.payload_len_in(rx_payload_len_in),
		.fcs_err_in(rx_fcs_err_in),
		.oversize_err_in(rx_oversize_err_in),
		.undersize_err_in(rx_undersize_err_in),
		.len_err_in(rx_len_err_in),
		.count_out(rx_frame_payload_count_out),
		.strobe_out(rx_frame_payload_count_strobe_out),
		.total_out(rx_payload_octet_total_out)
	);

	// Timestamp path decode
	// Capture happens on the arrival pulse only when the feature exists
	wire capture = precision_time_option & rx_link_arrival_in;
	// A held time is due to the client
	wire ts_ready = (ts_state == TS_HELD);
	// Client start of packet consumes the held time
	wire ts_take = rx_client_sop_in & ts_ready;
	// Capture gates per format
	wire cap_wide = capture & WIDE_OPTION;
	wire cap_narrow = capture & NARROW_OPTION;

	// Next state: arrival wins over a consuming start of packet,
	// so a packet arriving while the previous starts is not lost
	always_comb
	begin
		next_ts_state = ts_state;
		case (ts_state)
			TS_IDLE:
			begin
				if (capture)
					next_ts_state = TS_HELD;
			end
			TS_HELD:
			begin
				if (capture)
					next_ts_state = TS_HELD;
				else if (ts_take)
					next_ts_state = TS_SHOWN;
			end
			TS_SHOWN:
			begin
				// Value still shown until the next arrival
				if (capture)
					next_ts_state = TS_HELD;
			end
			default:
				next_ts_state = TS_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			ts_state <= TS_IDLE;
		else if (ce_in)
			ts_state <= next_ts_state;
	end

	// Hold the time seen at arrival; the live time is never shown
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			held_wide <= TOD_WIDE_RESET;
			held_narrow <= TOD_NARROW_RESET;
		end
		else if (ce_in)
		begin
			if (cap_wide)
				held_wide <= rx_tod_input_wide_in;
			if (cap_narrow)
				held_narrow <= rx_tod_input_narrow_in;
		end
	end

	// Only one timestamp is held: a second arrival before the first
	// start of packet overwrites it, trading depth for area
	assign rx_arrival_time_wide_out = held_wide;
	assign rx_arrival_time_narrow_out = held_narrow;
	// Qualifier rides with start of packet only while a stamp is held, any type
	assign rx_arrival_time_valid_out = ts_take;

	// Fingerprint pipeline: one register stage, bits untouched
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			fp_valid_q <= 1'b0;
			fp_q <= '0;
		end
		else if (ce_in)
		begin
			fp_valid_q <= fp_valid_in;
			if (fp_valid_in)
				fp_q <= fp_in;
		end
	end

	// Fingerprint outputs
	assign fp_valid_out = fp_valid_q;
	assign fp_out = fp_q;

	// Arrival captures the live time for later presentation
	wide_capture_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && cap_wide) |=>
			held_wide == $past(rx_tod_input_wide_in))
		else $error("wide time not captured");

	// Narrow format captured the same way
	narrow_capture_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && cap_narrow) |=>
			held_narrow == $past(rx_tod_input_narrow_in))
		else $error("narrow time not captured");

	// Held value does not follow the live time
	time_held_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(!cap_wide || !ce_in) |=> $stable(held_wide))
		else $error("held time drifted");

	// Pending stamp tracked apart from the state machine, so the check
	// below does not restate the decode; arrival wins, as in the design
	logic stamp_due;
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			stamp_due <= 1'b0;
		else if (ce_in && capture)
			stamp_due <= 1'b1;
		else if (ce_in && rx_client_sop_in)
			stamp_due <= 1'b0;
	end

	// Valid exactly on start of packet with a stamp pending
	sop_valid_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		rx_arrival_time_valid_out == (rx_client_sop_in && stamp_due))
		else $error("timestamp valid not on start of packet");

	// Narrow held value does not follow the live time either
	narrow_held_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(!cap_narrow || !ce_in) |=> $stable(held_narrow))
		else $error("held narrow time drifted");

	// A start of packet in the cycle after an arrival gets its stamp
	every_packet_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && capture) ##1 (ce_in && rx_client_sop_in &&
			!capture) |-> rx_arrival_time_valid_out)
		else $error("packet missed its timestamp");

	// Fingerprint comes back unchanged one cycle later
	fp_pass_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && fp_valid_in) |=>
			(fp_valid_out && fp_out == $past(fp_in)))
		else $error("fingerprint altered or lost");

	// Counts stay live with the totals configured out
	generate
		if (!STATS_OPTION)
		begin : g_no_stats_chk
			counts_alive_a: assert property (
				@(posedge clk_in) disable iff (srst_in)
				(ce_in && rx_frame_end_in && !rx_fcs_err_in &&
					!rx_oversize_err_in && !rx_undersize_err_in &&
					!rx_len_err_in) |=> rx_frame_payload_count_strobe_out)
				else $error("count dead without statistics");
		end
	endgenerate
endmodule

// >>> test/tod_source.sv
// Time source model for the arrival timestamp inputs.
// Assumes the bench clock; advances 10 ns of time on every rising edge.
module tod_source
	import frame_stats_pkg::*;
(
	input wire logic clk_in,
	output logic [TOD_WIDE_W-1:0] tod_wide_out,
	output logic [TOD_NARROW_W-1:0] tod_narrow_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Nonzero start, so a capture never matches the reset value
	initial
	begin
		tod_wide_out = 96'h0000_0000_0001_0000_0000_0000;
		tod_narrow_out = 64'h0000_0001_0000_0000;
	end
	// Never held, never reset; no carry into seconds, runs are short
	always @(posedge clk_in)
	begin
		tod_wide_out <= tod_wide_out + 96'h000a_0000;
		tod_narrow_out <= tod_narrow_out + 64'h000a_0000;
	end
endmodule

// >>> test/frame_octet_count_rx_timestamp_tb.sv
// Self-checking bench: payload tally, arrival time, fingerprint.
// Assumes one clock for both directions and the time source model.
module frame_octet_count_rx_timestamp_tb
	import frame_stats_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	// Index 0 is receive, 1 is transmit
	logic fe [2] = '{1'b0, 1'b0};
	logic [COUNT_W-1:0] ln [2] = '{16'h0000, 16'h0000};
	// Fcs, oversize, undersize, length error
	logic [3:0] er [2] = '{4'h0, 4'h0};
	logic arr = 1'b0;
	logic sop = 1'b0;
	// Clock enable, shared by both copies of the design
	logic ce = 1'b1;
	logic fpv = 1'b0;
	logic [7:0] fp = 8'h00;
	wire logic [COUNT_W-1:0] cnt [2];
	wire logic stb [2];
	wire logic [TOTAL_W-1:0] tot [2];
	wire logic [TOD_WIDE_W-1:0] tod_w;
	wire logic [TOD_WIDE_W-1:0] ts_w;
	wire logic [TOD_NARROW_W-1:0] tod_n;
	wire logic [TOD_NARROW_W-1:0] ts_n;
	wire logic ts_v;
	wire logic fpv_o;
	wire logic [7:0] fp_o;
	// Outputs of the copy without statistics totals
	wire logic [COUNT_W-1:0] cnt_ns [2];
	wire logic stb_ns [2];
	wire logic [TOTAL_W-1:0] tot_ns [2];
	// Expected totals, kept apart from the design
	logic [TOTAL_W-1:0] exp_tot [2] = '{64'h0, 64'h0};
	int miscompares = 0;
	int samples_checked = 0;
	always #5 clk_in = ~clk_in;
	tod_source u_tod_source (
		.clk_in(clk_in),
		.tod_wide_out(tod_w),
		.tod_narrow_out(tod_n)
	);
	frame_octet_count_rx_timestamp u_frame_octet_count_rx_timestamp (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce),
		.tx_frame_end_in(fe[1]),
		.tx_payload_len_in(ln[1]),
		.tx_fcs_err_in(er[1][0]),
		.tx_oversize_err_in(er[1][1]),
		.tx_undersize_err_in(er[1][2]),
		.tx_len_err_in(er[1][3]),
		.rx_frame_end_in(fe[0]),
		.rx_payload_len_in(ln[0]),
		.rx_fcs_err_in(er[0][0]),
		.rx_oversize_err_in(er[0][1]),
		.rx_undersize_err_in(er[0][2]),
		.rx_len_err_in(er[0][3]),
		.rx_link_arrival_in(arr),
		.rx_client_sop_in(sop),
		.rx_tod_input_wide_in(tod_w),
		.rx_tod_input_narrow_in(tod_n),
		.fp_valid_in(fpv),
		.fp_in(fp),
		.tx_frame_payload_count_out(cnt[1]),
		.tx_frame_payload_count_strobe_out(stb[1]),
		.rx_frame_payload_count_out(cnt[0]),
		.rx_frame_payload_count_strobe_out(stb[0]),
		.tx_payload_octet_total_out(tot[1]),
		.rx_payload_octet_total_out(tot[0]),
		.rx_arrival_time_wide_out(ts_w),
		.rx_arrival_time_narrow_out(ts_n),
		.rx_arrival_time_valid_out(ts_v),
		.fp_valid_out(fpv_o),
		.fp_out(fp_o)
	);
	// Second copy with totals configured out; counts must still work
	if (1)
	begin : g_no_stats
		frame_octet_count_rx_timestamp #(
			.STATS_OPTION(1'b0)
		) u_frame_octet_count_rx_timestamp (
			.clk_in(clk_in),
			.srst_in(srst_in),
			.ce_in(ce),
			.tx_frame_end_in(fe[1]),
			.tx_payload_len_in(ln[1]),
			.tx_fcs_err_in(er[1][0]),
			.tx_oversize_err_in(er[1][1]),
			.tx_undersize_err_in(er[1][2]),
			.tx_len_err_in(er[1][3]),
			.rx_frame_end_in(fe[0]),
			.rx_payload_len_in(ln[0]),
			.rx_fcs_err_in(er[0][0]),
			.rx_oversize_err_in(er[0][1]),
			.rx_undersize_err_in(er[0][2]),
			.rx_len_err_in(er[0][3]),
			.rx_link_arrival_in(arr),
			.rx_client_sop_in(sop),
			.rx_tod_input_wide_in(tod_w),
			.rx_tod_input_narrow_in(tod_n),
			.fp_valid_in(fpv),
			.fp_in(fp),
			.tx_frame_payload_count_out(cnt_ns[1]),
			.tx_frame_payload_count_strobe_out(stb_ns[1]),
			.rx_frame_payload_count_out(cnt_ns[0]),
			.rx_frame_payload_count_strobe_out(stb_ns[0]),
			.tx_payload_octet_total_out(tot_ns[1]),
			.rx_payload_octet_total_out(tot_ns[0]),
			.rx_arrival_time_wide_out(),
			.rx_arrival_time_narrow_out(),
			.rx_arrival_time_valid_out(),
			.fp_valid_out(),
			.fp_out()
		);
	end
	// Value compare; case equality so unknowns fail
	task cmp_val(input logic [95:0] got, input logic [95:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Flag compare
	task cmp_flag(input logic got, input logic exp);
		cmp_val({95'h0, got}, {95'h0, exp});
	endtask
	task complete_run;
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One frame end on direction d; an errored one must leave no trace
	task frame(input int d, input logic [15:0] len, input logic [3:0] e);
		@(posedge clk_in);
		fe[d] <= 1'b1;
		ln[d] <= len;
		er[d] <= e;
		@(posedge clk_in);
		fe[d] <= 1'b0;
		// Clear the flags so no later frame inherits an error
		er[d] <= 4'h0;
		#1;
		cmp_flag(stb[d], e == 4'h0);
		cmp_flag(stb_ns[d], e == 4'h0);
		if (e == 4'h0)
		begin
			cmp_val(96'(cnt[d]), 96'(len));
			cmp_val(96'(cnt_ns[d]), 96'(len));
			exp_tot[d] += 64'(len);
		end
		@(posedge clk_in);
		#1;
		cmp_flag(stb[d], 1'b0);
		cmp_val(96'(tot[d]), 96'(exp_tot[d]));
		cmp_val(96'(tot_ns[d]), 96'(TOTAL_RESET));
	endtask
	// Both directions, every error flag alone
	task tally_test;
		#1;
		cmp_val(96'(tot[0]), 96'(TOTAL_RESET));
		frame(0, 16'h05dc, 4'h0);
		frame(1, 16'h0040, 4'h0);
		for (int i = 0; i < 4; i++)
		begin
			frame(0, 16'h0040, 4'h1 << i);
			frame(1, 16'h0040, 4'h1 << i);
		end
		$display("tally test done");
	endtask
	// Back-to-back frames, the first at the count limit; total carries past 16 bits
	task tally_back;
		@(posedge clk_in);
		fe[1] <= 1'b1;
		ln[1] <= 16'hffff;
		@(posedge clk_in);
		ln[1] <= 16'h0001;
		#1;
		cmp_val(96'(cnt[1]), 96'hffff);
		@(posedge clk_in);
		fe[1] <= 1'b0;
		#1;
		cmp_flag(stb[1], 1'b1);
		cmp_val(96'(cnt[1]), 96'h0001);
		cmp_val(96'(tot[1]), 96'(exp_tot[1] + 64'hffff));
		@(posedge clk_in);
		#1;
		exp_tot[1] += 64'h10000;
		cmp_val(96'(tot[1]), 96'(exp_tot[1]));
		$display("back to back test done");
	endtask
	// Stray start, then capture at arrival and delivery at start
	task arrival_time;
		logic [TOD_WIDE_W-1:0] exp_w;
		logic [TOD_NARROW_W-1:0] exp_n;
		@(posedge clk_in);
		sop <= 1'b1;
		#1;
		cmp_flag(ts_v, 1'b0);
		@(posedge clk_in);
		sop <= 1'b0;
		arr <= 1'b1;
		#1;
		exp_w = tod_w;
		exp_n = tod_n;
		@(posedge clk_in);
		arr <= 1'b0;
		repeat (3) @(posedge clk_in);
		sop <= 1'b1;
		#1;
		cmp_flag(ts_v, 1'b1);
		cmp_val(ts_w, exp_w);
		cmp_val(96'(ts_n), 96'(exp_n));
		@(posedge clk_in);
		#1;
		cmp_flag(ts_v, 1'b0);
		// Start of packet right after arrival still carries the stamp
		@(posedge clk_in);
		sop <= 1'b0;
		arr <= 1'b1;
		#1;
		exp_w = tod_w;
		exp_n = tod_n;
		@(posedge clk_in);
		arr <= 1'b0;
		sop <= 1'b1;
		#1;
		cmp_flag(ts_v, 1'b1);
		cmp_val(ts_w, exp_w);
		cmp_val(96'(ts_n), 96'(exp_n));
		@(posedge clk_in);
		sop <= 1'b0;
		$display("arrival time test done");
	endtask
	// Enable low freezes strobe and total and takes no frame end
	task freeze_test;
		@(posedge clk_in);
		fe[0] <= 1'b1;
		ln[0] <= 16'h0100;
		@(posedge clk_in);
		ce <= 1'b0;
		ln[0] <= 16'h0200;
		#1;
		cmp_flag(stb[0], 1'b1);
		@(posedge clk_in);
		ce <= 1'b1;
		fe[0] <= 1'b0;
		#1;
		cmp_flag(stb[0], 1'b1);
		cmp_val(96'(tot[0]), 96'(exp_tot[0]));
		@(posedge clk_in);
		#1;
		exp_tot[0] += 64'h0100;
		cmp_flag(stb[0], 1'b0);
		cmp_val(96'(cnt[0]), 96'h0100);
		cmp_val(96'(tot[0]), 96'(exp_tot[0]));
		$display("freeze test done");
	endtask
	// Fingerprint comes back one cycle later, unaltered
	task fingerprint;
		@(posedge clk_in);
		fpv <= 1'b1;
		fp <= 8'ha5;
		@(posedge clk_in);
		fpv <= 1'b0;
		#1;
		cmp_flag(fpv_o, 1'b1);
		cmp_val(96'(fp_o), 96'ha5);
		@(posedge clk_in);
		#1;
		cmp_flag(fpv_o, 1'b0);
		$display("fingerprint test done");
	endtask
	initial
	begin
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		tally_test;
		tally_back;
		arrival_time;
		fingerprint;
		freeze_test;
		complete_run;
	end
	// Tests take about 53 cycles; over eleven times that before giving up
	initial
	begin
		#6000;
		miscompares++;
		complete_run;
	end
endmodule
